//--- verilog/dub_pkg.sv
// package: constants and types for the dual-channel serial board host interface
package dub_pkg;

   // ------------------------------------------------------------
   // channel register offsets
   // ------------------------------------------------------------
   localparam logic [2:0] OFS_DATA      = 3'h0;
   localparam logic [2:0] OFS_IER       = 3'h1;
   localparam logic [2:0] OFS_IID_FCTL  = 3'h2;
   localparam logic [2:0] OFS_LINE_CTL  = 3'h3;
   localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
   localparam logic [2:0] OFS_LINE_STAT = 3'h5;
   localparam logic [2:0] OFS_MODEM_ST  = 3'h6;
   localparam logic [2:0] OFS_SCRATCH   = 3'h7;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int         DIV_SELECT_BIT   = 7;
   localparam int         AUX_OUT_ONE_BIT  = 2;
   localparam int         GLOBAL_IRQ_BIT   = 7;
   localparam logic [7:0] LINE_CTL_RESET   = 8'h00;
   localparam logic [7:0] MODEM_CTL_RESET  = 8'h04;
   localparam logic [7:0] IER_RESET        = 8'h00;
   localparam logic [7:0] SCRATCH_RESET    = 8'h00;
   localparam logic [7:0] FIFO_CTL_RESET   = 8'h00;
   localparam logic [15:0] DIVISOR_RESET   = 16'h0001;
   localparam logic [7:0] IID_NONE         = 8'h01;
   localparam logic [7:0] IID_RX_AVAIL     = 8'h04;
   localparam logic [7:0] IID_TX_EMPTY     = 8'h02;

   // ------------------------------------------------------------
   // vector register addresses and request levels
   // ------------------------------------------------------------
   localparam logic [9:0] VECTOR_ADDR_A    = 10'h2BF;
   localparam logic [9:0] VECTOR_ADDR_B    = 10'h1BF;
   localparam logic [15:0] LEVEL_ALLOWED   = 16'hDEF8;
   localparam int         NUM_LEVELS       = 16;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int         OVERSAMPLE       = 16;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [2:0] ofs;
      logic [7:0] wdata;
   } dub_access_type;

   typedef struct packed {
      logic       rx_valid;
      logic [7:0] rx_data;
      logic       tx_ready;
      logic [7:0] modem_in;
   } dub_line_type;

endpackage : dub_pkg

//--- verilog/dub_channel.sv
// module: one serial element register file with divisor and baud generator
`timescale 1ns/1ps
module dub_channel
   import dub_pkg::*;
#(
   parameter int DIV_W = 16
) (
   // clock and reset
   input  wire logic           clock_i,
   input  wire logic           rstn_i,
   // register access
   input  wire dub_access_type acc_i,
   output logic [7:0]          rdata_o,
   // reference tick at 1.8432 MHz rate
   input  wire logic           ref_tick_i,
   // line side
   input  wire dub_line_type   line_i,
   output logic                tx_load_o,
   output logic [7:0]          tx_data_o,
   output logic                rx_take_o,
   output logic                baud16_tick_o,
   output logic [15:0]         divisor_o,
   output logic [7:0]          line_ctl_o,
   output logic [7:0]          modem_ctl_o,
   output logic [7:0]          fifo_ctl_o,
   output logic                irq_o
);

   logic [7:0]       line_ctl_q;
   logic [7:0]       modem_ctl_q;
   logic [7:0]       ier_q;
   logic [7:0]       scratch_q;
   logic [7:0]       fifo_ctl_q;
   logic [DIV_W-1:0] divisor_q;
   logic [DIV_W-1:0] count_q;
   logic [7:0]       tx_data_q;
   logic             tx_load_q;
   logic             divisor_select;
   logic [7:0]       iid;

   assign divisor_select = line_ctl_q[DIV_SELECT_BIT];

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         line_ctl_q  <= LINE_CTL_RESET;
         modem_ctl_q <= MODEM_CTL_RESET;
         ier_q       <= IER_RESET;
         scratch_q   <= SCRATCH_RESET;
         fifo_ctl_q  <= FIFO_CTL_RESET;
         divisor_q   <= DIVISOR_RESET;
         tx_data_q   <= 8'h00;
         tx_load_q   <= 1'b0;
      end else begin
         tx_load_q <= 1'b0;
         if (acc_i.wr) begin
            case (acc_i.ofs)
               OFS_DATA: begin
                  if (divisor_select) begin
                     divisor_q[7:0] <= acc_i.wdata;
                  end else begin
                     tx_data_q <= acc_i.wdata;
                     tx_load_q <= 1'b1;
                  end
               end
               OFS_IER: begin
                  if (divisor_select) begin
                     divisor_q[15:8] <= acc_i.wdata;
                  end else begin
                     ier_q <= {4'h0, acc_i.wdata[3:0]};
                  end
               end
               OFS_IID_FCTL:  fifo_ctl_q  <= acc_i.wdata;
               OFS_LINE_CTL:  line_ctl_q  <= acc_i.wdata;
               OFS_MODEM_CTL: modem_ctl_q <= {3'h0, acc_i.wdata[4:0]};
               OFS_SCRATCH:   scratch_q   <= acc_i.wdata;
               default: begin
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // baud generator: reference divided by divisor, 16x baud
   // ------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         count_q       <= '0;
         baud16_tick_o <= 1'b0;
      end else begin
         baud16_tick_o <= 1'b0;
         if (ref_tick_i) begin
            if (count_q + 1'b1 >= divisor_q || divisor_q == '0) begin
               count_q       <= '0;
               baud16_tick_o <= 1'b1;
            end else begin
               count_q <= count_q + 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt identification and read mux
   // ------------------------------------------------------------
   always_comb begin
      if (ier_q[0] && line_i.rx_valid) begin
         iid = IID_RX_AVAIL;
      end else if (ier_q[1] && line_i.tx_ready) begin
         iid = IID_TX_EMPTY;
      end else begin
         iid = IID_NONE;
      end
   end

   always_comb begin
      rdata_o = 8'h00;
      case (acc_i.ofs)
         OFS_DATA:      rdata_o = divisor_select ? divisor_q[7:0] : line_i.rx_data;
         OFS_IER:       rdata_o = divisor_select ? divisor_q[15:8] : ier_q;
         OFS_IID_FCTL:  rdata_o = iid;
         OFS_LINE_CTL:  rdata_o = line_ctl_q;
         OFS_MODEM_CTL: rdata_o = modem_ctl_q;
         OFS_LINE_STAT: rdata_o = {1'b0, line_i.tx_ready, line_i.tx_ready, 4'h0,
                                   line_i.rx_valid};
         OFS_MODEM_ST:  rdata_o = line_i.modem_in;
         OFS_SCRATCH:   rdata_o = scratch_q;
         default:       rdata_o = 8'h00;
      endcase
   end

   assign rx_take_o   = acc_i.rd && acc_i.ofs == OFS_DATA && !divisor_select;
   assign tx_load_o   = tx_load_q;
   assign tx_data_o   = tx_data_q;
   assign divisor_o   = divisor_q;
   assign line_ctl_o  = line_ctl_q;
   assign modem_ctl_o = modem_ctl_q;
   assign fifo_ctl_o  = fifo_ctl_q;
   assign irq_o       = (iid != IID_NONE);

endmodule // dub_channel

//--- verilog/dub_board.sv
// module: two-channel serial board host-bus interface, top level
`timescale 1ns/1ps
module dub_board
   import dub_pkg::*;
#(
   parameter int ADDR_W  = 10,
   parameter int REF_NUM = 1152,
   parameter int REF_DEN = 12500
) (
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   // host bus
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              ior_i,
   input  wire logic              iow_i,
   input  wire logic [7:0]        wdata_i,
   output logic [7:0]             rdata_o,
   output logic                   rdata_oe_o,
   // board configuration
   input  wire logic              enhanced_mode_i,
   input  wire logic              vector_addr_alt_i,
   input  wire logic [ADDR_W-4:0] chan0_base_i,
   input  wire logic [ADDR_W-4:0] chan1_base_i,
   input  wire logic [3:0]        shared_irq_jumper_i,
   input  wire logic [3:0]        first_port_irq_jumper_i,
   input  wire logic [3:0]        second_port_irq_jumper_i,
   // line side, per channel
   input  wire dub_line_type      line0_i,
   input  wire dub_line_type      line1_i,
   output logic [1:0]             tx_load_o,
   output logic [15:0]            tx_data_o,
   output logic [1:0]             rx_take_o,
   output logic [1:0]             baud16_tick_o,
   output logic [31:0]            divisor_o,
   output logic [15:0]            line_ctl_o,
   output logic [15:0]            modem_ctl_o,
   output logic [15:0]            fifo_ctl_o,
   // host request levels
   output logic [NUM_LEVELS-1:0]  irq_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [NUM_LEVELS-1:0] route(input logic [3:0] lvl, input logic req);
      logic [NUM_LEVELS-1:0] v;
      v = '0;
      v[lvl] = req & LEVEL_ALLOWED[lvl];
      return v;
   endfunction

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-4:0] b);
      return a[ADDR_W-1:3] == b;
   endfunction

   // ------------------------------------------------------------
   // reference tick: fractional accumulator for 1.8432 MHz
   // ------------------------------------------------------------
   logic [15:0] ref_acc_q;
   logic        ref_tick_q;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         ref_acc_q  <= 16'h0000;
         ref_tick_q <= 1'b0;
      end else if (ref_acc_q + 16'(REF_NUM) >= 16'(REF_DEN)) begin
         ref_acc_q  <= 16'(ref_acc_q + 16'(REF_NUM) - 16'(REF_DEN));
         ref_tick_q <= 1'b1;
      end else begin
         ref_acc_q  <= 16'(ref_acc_q + 16'(REF_NUM));
         ref_tick_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   logic [1:0]       sel;
   logic             vec_sel;
   logic [ADDR_W-1:0] vec_addr;
   dub_access_type   acc [2];
   logic [7:0]       ch_rdata [2];
   logic [1:0]       ch_irq;

   assign vec_addr = vector_addr_alt_i ? ADDR_W'(VECTOR_ADDR_B) : ADDR_W'(VECTOR_ADDR_A);
   assign vec_sel  = enhanced_mode_i && addr_i == vec_addr;
   assign sel[0]   = hit(addr_i, chan0_base_i) && !vec_sel;
   assign sel[1]   = hit(addr_i, chan1_base_i) && !vec_sel && !sel[0];

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         acc[i].rd    = ior_i && sel[i];
         acc[i].wr    = iow_i && sel[i];
         acc[i].ofs   = addr_i[2:0];
         acc[i].wdata = wdata_i;
      end
   end

   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   dub_channel u_chan0 (
      .clock_i       (clock_i),
      .rstn_i        (rstn_i),
      .acc_i         (acc[0]),
      .rdata_o       (ch_rdata[0]),
      .ref_tick_i    (ref_tick_q),
      .line_i        (line0_i),
      .tx_load_o     (tx_load_o[0]),
      .tx_data_o     (tx_data_o[7:0]),
      .rx_take_o     (rx_take_o[0]),
      .baud16_tick_o (baud16_tick_o[0]),
      .divisor_o     (divisor_o[15:0]),
      .line_ctl_o    (line_ctl_o[7:0]),
      .modem_ctl_o   (modem_ctl_o[7:0]),
      .fifo_ctl_o    (fifo_ctl_o[7:0]),
      .irq_o         (ch_irq[0])
   );

   dub_channel u_chan1 (
      .clock_i       (clock_i),
      .rstn_i        (rstn_i),
      .acc_i         (acc[1]),
      .rdata_o       (ch_rdata[1]),
      .ref_tick_i    (ref_tick_q),
      .line_i        (line1_i),
      .tx_load_o     (tx_load_o[1]),
      .tx_data_o     (tx_data_o[15:8]),
      .rx_take_o     (rx_take_o[1]),
      .baud16_tick_o (baud16_tick_o[1]),
      .divisor_o     (divisor_o[31:16]),
      .line_ctl_o    (line_ctl_o[15:8]),
      .modem_ctl_o   (modem_ctl_o[15:8]),
      .fifo_ctl_o    (fifo_ctl_o[15:8]),
      .irq_o         (ch_irq[1])
   );

   // ------------------------------------------------------------
   // vector register and global enable
   // ------------------------------------------------------------
   logic       global_en_q;
   logic [1:0] pend_q;
   logic [1:0] gated;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         global_en_q <= 1'b0;
      end else if (iow_i && vec_sel) begin
         global_en_q <= wdata_i[GLOBAL_IRQ_BIT];
      end
   end

   assign gated[0] = ch_irq[0] && modem_ctl_o[AUX_OUT_ONE_BIT];
   assign gated[1] = ch_irq[1] && modem_ctl_o[8 + AUX_OUT_ONE_BIT];

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         pend_q <= 2'b00;
      end else begin
         pend_q <= gated;
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      rdata_o    = 8'h00;
      rdata_oe_o = 1'b0;
      if (ior_i && vec_sel) begin
         rdata_o    = {global_en_q, 5'h00, pend_q};
         rdata_oe_o = 1'b1;
      end else if (ior_i && sel[0]) begin
         rdata_o    = ch_rdata[0];
         rdata_oe_o = 1'b1;
      end else if (ior_i && sel[1]) begin
         rdata_o    = ch_rdata[1];
         rdata_oe_o = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // request routing
   // ------------------------------------------------------------
   always_comb begin
      if (enhanced_mode_i) begin
         irq_o = route(shared_irq_jumper_i, global_en_q && |pend_q);
      end else begin
         irq_o = route(first_port_irq_jumper_i, ch_irq[0])
               | route(second_port_irq_jumper_i, ch_irq[1]);
      end
   end

endmodule // dub_board

//--- sim/dub_board_sva.sv
// checker: host-interface assertions for the dual-channel serial board
`timescale 1ns/1ps
module dub_board_sva
   import dub_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   // clock and reset
   input wire logic                  clock_i,
   input wire logic                  rstn_i,
   // host bus and configuration
   input wire logic [ADDR_W-1:0]     addr_i,
   input wire logic                  ior_i,
   input wire logic                  iow_i,
   input wire logic [7:0]            wdata_i,
   input wire logic                  rdata_oe_o,
   input wire logic                  enhanced_mode_i,
   input wire logic [ADDR_W-4:0]     chan0_base_i,
   input wire logic [ADDR_W-4:0]     chan1_base_i,
   // watched outputs
   input wire logic [1:0]            tx_load_o,
   input wire logic [15:0]           tx_data_o,
   input wire logic [31:0]           divisor_o,
   input wire logic [15:0]           line_ctl_o,
   input wire logic [15:0]           modem_ctl_o,
   input wire logic [NUM_LEVELS-1:0] irq_o
);
   // ------------------------------------------------------------
   // channel 0 and 1 decode and board properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic hit0;
   logic hit1;
   assign hit0 = (addr_i[ADDR_W-1:3] == chan0_base_i);
   assign hit1 = (addr_i[ADDR_W-1:3] == chan1_base_i);
   sequence s_wr0(o, dls);
      iow_i && hit0 && (addr_i[2:0] == o) && (line_ctl_o[7] == dls);
   endsequence
   AST_RESET: assert property ($rose(rstn_i) |-> modem_ctl_o == 16'h0404
      && divisor_o == 32'h0001_0001) else $error("reset values wrong");
   AST_GLOBAL_OFF: assert property ($rose(rstn_i) && enhanced_mode_i
      |-> irq_o == 16'h0000) else $error("request before global enable");
   AST_UNMAPPED: assert property (ior_i && !hit0 && !hit1 && addr_i != VECTOR_ADDR_A
      && addr_i != VECTOR_ADDR_B |-> !rdata_oe_o) else $error("unmapped read driven");
   AST_TXLOAD: assert property (s_wr0(3'h0, 1'b0) |=> tx_load_o[0]
      && tx_data_o[7:0] == $past(wdata_i)) else $error("transmit load wrong");
   AST_DIV_LO: assert property (s_wr0(3'h0, 1'b1) |=> !tx_load_o[0]
      && divisor_o[7:0] == $past(wdata_i)) else $error("divisor low wrong");
   AST_DIV_HI: assert property (s_wr0(3'h1, 1'b1)
      |=> divisor_o[15:8] == $past(wdata_i)) else $error("divisor high wrong");
   AST_LINE_CTL: assert property (iow_i && hit0 && addr_i[2:0] == 3'h3
      |=> line_ctl_o[7:0] == $past(wdata_i)) else $error("line control wrong");
   AST_LEVELS: assert property ((irq_o & ~LEVEL_ALLOWED) == 16'h0000)
      else $error("request on disallowed level");
   AST_SHARED: assert property (enhanced_mode_i |-> $onehot0(irq_o))
      else $error("more than one shared line");
   AST_MAPPED_OE: assert property (ior_i && hit0 && addr_i != VECTOR_ADDR_A
      && addr_i != VECTOR_ADDR_B |-> rdata_oe_o) else $error("mapped read not driven");
endmodule // dub_board_sva

bind dub_board dub_board_sva #(.ADDR_W(ADDR_W)) u_sva (
   .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .ior_i(ior_i), .iow_i(iow_i),
   .wdata_i(wdata_i), .rdata_oe_o(rdata_oe_o), .enhanced_mode_i(enhanced_mode_i),
   .chan0_base_i(chan0_base_i), .chan1_base_i(chan1_base_i), .tx_load_o(tx_load_o),
   .tx_data_o(tx_data_o), .divisor_o(divisor_o), .line_ctl_o(line_ctl_o),
   .modem_ctl_o(modem_ctl_o), .irq_o(irq_o));

//--- sim/dub_host_model.sv
// host model: register reads and writes on the board's I/O bus
`timescale 1ns/1ps
module dub_host_model (
   // clock
   input  wire logic       clock_i,
   // host bus
   output logic [9:0]      addr_o,
   output logic            ior_o,
   output logic            iow_o,
   output logic [7:0]      wdata_o,
   input  wire logic [7:0] rdata_i
);
   // ------------------------------------------------------------
   // bus cycles, each followed by a recovery read
   // ------------------------------------------------------------
   localparam logic [9:0] RECOVER_ADDR = 10'h2EF;
   logic [7:0] dummy;
   initial begin
      addr_o  = 10'h000;
      ior_o   = 1'b0;
      iow_o   = 1'b0;
      wdata_o = 8'h00;
   end
   task automatic cyc_rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr_o <= a;
      ior_o  <= 1'b1;
      @(posedge clock_i);
      d = rdata_i;
      ior_o  <= 1'b0;
      addr_o <= ~a;
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      cyc_rd(a, d);
      cyc_rd(RECOVER_ADDR, dummy);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_o  <= a;
      wdata_o <= d;
      iow_o   <= 1'b1;
      @(posedge clock_i);
      iow_o   <= 1'b0;
      wdata_o <= ~d;
      cyc_rd(RECOVER_ADDR, dummy);
   endtask
endmodule // dub_host_model

//--- sim/tb_top.sv
// testbench: scenarios for the dual-channel serial board host interface
`timescale 1ns/1ps
module tb_top
   import dub_pkg::*;
;
   // ------------------------------------------------------------
   // signals, instances and monitors
   // ------------------------------------------------------------
   localparam logic [6:0] B0 = 7'h7F;
   localparam logic [6:0] B1 = 7'h5F;
   logic         clock_i = 1'b0;
   logic         rstn_i = 1'b0;
   logic [9:0]   addr;
   logic         ior, iow, oe, enh, alt;
   logic [7:0]   wdata, rdata, txd;
   logic [3:0]   j_sh, j_p1, j_p2;
   dub_line_type l0, l1;
   logic [1:0]   tx_load, rx_take, b16;
   logic [15:0]  tx_data, lctl, mctl, fctl, irq;
   logic [31:0]  divisor;
   int           mismatches = 0;
   int           tests_run = 0;
   int           txc = 0;
   int           bc0 = 0;
   int           bc1 = 0;
   int           rxc = 0;
   always #25 clock_i = ~clock_i;
   dub_board dut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .ior_i(ior),
      .iow_i(iow), .wdata_i(wdata), .rdata_o(rdata), .rdata_oe_o(oe),
      .enhanced_mode_i(enh), .vector_addr_alt_i(alt), .chan0_base_i(B0),
      .chan1_base_i(B1), .shared_irq_jumper_i(j_sh), .first_port_irq_jumper_i(j_p1),
      .second_port_irq_jumper_i(j_p2), .line0_i(l0), .line1_i(l1), .tx_load_o(tx_load),
      .tx_data_o(tx_data), .rx_take_o(rx_take), .baud16_tick_o(b16), .divisor_o(divisor),
      .line_ctl_o(lctl), .modem_ctl_o(mctl), .fifo_ctl_o(fctl), .irq_o(irq));
   dub_host_model host (.clock_i(clock_i), .addr_o(addr), .ior_o(ior), .iow_o(iow),
      .wdata_o(wdata), .rdata_i(rdata));
   always @(posedge clock_i) begin
      if (tx_load[0] === 1'b1) begin
         txc++;
         txd = tx_data[7:0];
      end
      if (b16[0] === 1'b1) bc0++;
      if (b16[1] === 1'b1) bc1++;
      if (rx_take[0] === 1'b1) rxc++;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk("divisor", 32'h0001_0001, divisor);
      chk("modem_ctl", 16'h0404, mctl);
      chk("line_ctl", 16'h0000, lctl);
      chk("fifo_ctl", 16'h0000, fctl);
      chk("irq", 16'h0000, irq);
   endtask
   task automatic t_regs();
      logic [2:0] ofs [4];
      logic [7:0] val [4];
      logic [7:0] d;
      ofs = '{3'h1, 3'h3, 3'h4, 3'h7};
      val = '{8'h05, 8'h1B, 8'h13, 8'hA5};
      @(posedge clock_i);
      l0.rx_data <= 8'h3C;
      host.wr({B1, 3'h7}, 8'h5A);
      for (int i = 0; i < 4; i++) begin
         host.wr({B0, ofs[i]}, val[i]);
         host.rd({B0, ofs[i]}, d);
         chk("reg_readback", val[i], d);
      end
      host.rd({B1, 3'h7}, d);
      chk("ch1_scratch", 8'h5A, d);
      host.rd({B0, 3'h0}, d);
      chk("rx_buffer", 8'h3C, d);
      chk("rx_takes", 1, rxc);
      host.wr({B0, 3'h2}, 8'hC1);
      chk("fifo_ctl", 8'hC1, fctl[7:0]);
      host.rd({B0, 3'h2}, d);
      chk("irq_id", IID_NONE, d);
      host.rd(10'h2EF, d);
      chk("unmapped", 8'h00, d);
      host.wr({B0, 3'h4}, 8'h04);
      host.wr({B0, 3'h1}, 8'h00);
   endtask
   task automatic t_div();
      logic [7:0] d;
      host.wr({B0, 3'h3}, 8'h83);
      host.wr({B0, 3'h0}, 8'h0C);
      host.wr({B0, 3'h1}, 8'h12);
      chk("divisor", 16'h120C, divisor[15:0]);
      host.rd({B0, 3'h0}, d);
      chk("div_low", 8'h0C, d);
      chk("rx_takes", 1, rxc);
      host.rd({B0, 3'h1}, d);
      chk("div_high", 8'h12, d);
      chk("tx_loads", 0, txc);
      host.wr({B0, 3'h1}, 8'h00);
      host.wr({B0, 3'h3}, 8'h03);
      chk("line_ctl", 8'h03, lctl[7:0]);
      host.rd({B0, 3'h1}, d);
      chk("ier_back", 8'h00, d);
      host.wr({B0, 3'h0}, 8'h41);
      chk("tx_loads", 1, txc);
      chk("tx_data", 8'h41, txd);
   endtask
   task automatic t_baud();
      bc0 = 0;
      bc1 = 0;
      repeat (12500) @(posedge clock_i);
      chk("rate_ch0", 1'b1, bc0 >= 95 && bc0 <= 97);
      chk("rate_ch1", 1'b1, bc1 >= 1151 && bc1 <= 1153);
   endtask
   task automatic t_irq();
      logic [7:0] d;
      host.wr({B0, 3'h1}, 8'h01);
      @(posedge clock_i);
      l0.rx_valid <= 1'b1;
      host.rd(VECTOR_ADDR_A, d);
      chk("vector", 8'h01, d);
      chk("irq_gated", 16'h0000, irq);
      host.rd({B0, 3'h2}, d);
      chk("irq_id_rx", IID_RX_AVAIL, d);
      host.rd({B0, 3'h5}, d);
      chk("line_status", 8'h01, d);
      host.wr(VECTOR_ADDR_A, 8'h80);
      chk("irq_shared", 16'h0020, irq);
      host.wr({B0, 3'h4}, 8'h00);
      chk("irq_aux_off", 16'h0000, irq);
      host.wr({B0, 3'h4}, 8'h04);
      @(posedge clock_i);
      alt <= 1'b1;
      host.rd(VECTOR_ADDR_B, d);
      chk("vector_alt", 8'h81, d);
      chk("irq_level", 16'h0020, irq);
      @(posedge clock_i);
      l0.rx_valid <= 1'b0;
      host.rd(VECTOR_ADDR_B, d);
      chk("vector_clear", 8'h80, d);
   endtask
   task automatic t_compat();
      host.wr({B1, 3'h1}, 8'h02);
      @(posedge clock_i);
      enh <= 1'b0;
      l0.rx_valid <= 1'b1;
      l1.tx_ready <= 1'b1;
      repeat (2) @(posedge clock_i);
      chk("irq_compat", 16'h0018, irq);
   endtask
   initial begin
      enh = 1'b1;
      alt = 1'b0;
      j_sh = 4'h5;
      j_p1 = 4'h4;
      j_p2 = 4'h3;
      l0 = '0;
      l1 = '0;
      repeat (12) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      t_reset();
      t_regs();
      t_div();
      t_baud();
      t_irq();
      t_compat();
      complete_run();
   end
   initial begin
      repeat (100000) @(posedge clock_i);
      mismatches++;
      complete_run();
   end
endmodule // tb_top
